//--- logic/wdt_pkg.sv
// constants, register map and field layout of the watchdog interval timer
// assumes a single 10 MHz clock and an AXI4-Lite master with 32-bit data
package wdt_pkg;
  localparam logic [31:0] ADDR_CONTROL = 32'h5300_0000;
  localparam logic [31:0] ADDR_RELOAD  = 32'h5300_0004;
  localparam logic [31:0] ADDR_COUNT   = 32'h5300_0008;
  localparam logic [31:0] ADDR_STATUS  = 32'h5300_000c;
  localparam logic [31:0] ADDR_MASK    = 32'h5300_0010;

  localparam logic [15:0] CONTROL_RESET = 16'h8021;
  localparam logic [15:0] RELOAD_RESET  = 16'h8000;
  localparam logic [15:0] COUNT_RESET   = 16'h8000;

  localparam int PRESC_HI = 15;
  localparam int PRESC_LO = 8;
  localparam int EN_BIT   = 5;
  localparam int SEL_HI   = 4;
  localparam int SEL_LO   = 3;
  localparam int INT_BIT  = 2;
  localparam int RST_BIT  = 0;

  localparam logic [1:0] SEL_DIV16  = 2'h0;
  localparam logic [1:0] SEL_DIV32  = 2'h1;
  localparam logic [1:0] SEL_DIV64  = 2'h2;
  localparam logic [6:0] LAST_DIV16  = 7'h0f;
  localparam logic [6:0] LAST_DIV32  = 7'h1f;
  localparam logic [6:0] LAST_DIV64  = 7'h3f;
  localparam logic [6:0] LAST_DIV128 = 7'h7f;

  localparam int STS_TIMEOUT = 0;
  localparam int STS_RESET   = 1;
  localparam int STS_W       = 2;

  localparam logic [7:0]  RST_CYCLES = 8'h80;
  localparam logic [15:0] ONE16      = 16'h0001;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- logic/watchdog_interval_timer.sv
// watchdog / interval timer with AXI4-Lite register slave
// assumes all inputs synchronous to aclk; system_reset_out feeds the chip reset tree
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module watchdog_interval_timer
  import wdt_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        debug_acknowledge,
  output logic             system_reset_out,
  output logic             timer_irq
);

  function automatic logic [6:0] div_last(input logic [1:0] sel);
    case (sel)
      SEL_DIV16: div_last = LAST_DIV16;
      SEL_DIV32: div_last = LAST_DIV32;
      SEL_DIV64: div_last = LAST_DIV64;
      default:   div_last = LAST_DIV128;
    endcase
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) merge16[7:0] = d[7:0];
    if (strb[1]) merge16[15:8] = d[15:8];
  endfunction

  // expected tick spacing, worked out apart from the two counters that make it
  function automatic logic [15:0] period_of(input logic [15:0] ctrl);
    period_of = (({8'h00, ctrl[PRESC_HI:PRESC_LO]} + ONE16) * ({9'h000, LAST_DIV16} + ONE16))
                << ctrl[SEL_HI:SEL_LO];
  endfunction

  logic [15:0]       control_r;
  logic [15:0]       reload_r;
  logic [15:0]       count_r;
  logic [STS_W-1:0]  status_r;
  logic [STS_W-1:0]  mask_r;
  logic [7:0]        pre_cnt_r;
  logic [6:0]        div_cnt_r;
  logic [7:0]        rst_cnt_r;
  logic [31:0]       awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              aw_held_r;
  logic              w_held_r;

  logic              enabled;
  logic              pre_pulse;
  logic              tick;
  logic              timeout;
  logic              fire_reset;
  logic              wr_go;
  logic              wr_ctrl;
  logic              wr_reload;
  logic              wr_count;
  logic              wr_status;
  logic              wr_mask;
  logic              wr_hit;
  logic [15:0]       cnt_nxt;
  logic [31:0]       rdata_nxt;
  logic              rd_hit;

  assign enabled   = control_r[EN_BIT];
  // prescaler then division factor, both only from aclk
  assign pre_pulse = enabled && (pre_cnt_r == control_r[PRESC_HI:PRESC_LO]);
  assign tick      = pre_pulse && (div_cnt_r == div_last(control_r[SEL_HI:SEL_LO]));
  // a count of one expires this tick and loads reload_r; a written zero also expires
  assign timeout   = tick && (count_r <= ONE16);
  assign fire_reset = timeout && control_r[RST_BIT] && !debug_acknowledge;

  always_ff @(posedge aclk) begin
    if (!aresetn || !enabled) begin
      pre_cnt_r <= '0;
    end else if (pre_pulse) begin
      pre_cnt_r <= '0;
    end else begin
      pre_cnt_r <= pre_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !enabled) begin
      div_cnt_r <= '0;
    end else if (tick) begin
      div_cnt_r <= '0;
    end else if (pre_pulse) begin
      div_cnt_r <= div_cnt_r + 7'h01;
    end
  end

  // write port
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign wr_go     = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_ctrl   = wr_go && (awaddr_r == ADDR_CONTROL);
  assign wr_reload = wr_go && (awaddr_r == ADDR_RELOAD);
  assign wr_count  = wr_go && (awaddr_r == ADDR_COUNT);
  assign wr_status = wr_go && (awaddr_r == ADDR_STATUS);
  assign wr_mask   = wr_go && (awaddr_r == ADDR_MASK);
  assign wr_hit    = wr_ctrl || wr_reload || wr_count || wr_status || wr_mask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r  <= '0;
      wstrb_r  <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // reserved control bits are stored as written; they steer nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_r <= CONTROL_RESET;
    end else if (wr_ctrl) begin
      control_r <= merge16(control_r, wdata_r, wstrb_r);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_r <= RELOAD_RESET;
    end else if (wr_reload) begin
      reload_r <= merge16(reload_r, wdata_r, wstrb_r);
    end
  end

  // a software write beats a tick in the same cycle so a kick is never undone;
  // enabling never loads the reload value, counting resumes from count_r
  always_comb begin
    cnt_nxt = count_r;
    if (wr_count) begin
      cnt_nxt = merge16(count_r, wdata_r, wstrb_r);
    end else if (timeout) begin
      cnt_nxt = reload_r;
    end else if (tick) begin
      cnt_nxt = count_r - ONE16;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= COUNT_RESET;
    end else begin
      count_r <= cnt_nxt;
    end
  end

  // a timeout while the pulse runs does not stretch it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_cnt_r <= '0;
    end else if (rst_cnt_r != 8'h00) begin
      rst_cnt_r <= rst_cnt_r - 8'h01;
    end else if (fire_reset) begin
      rst_cnt_r <= RST_CYCLES;
    end
  end

  assign system_reset_out = (rst_cnt_r != 8'h00);

  // sticky events, set wins over a write-one clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= '0;
    end else begin
      status_r[STS_TIMEOUT] <= (timeout && control_r[INT_BIT]) ||
        (status_r[STS_TIMEOUT] && !(wr_status && wstrb_r[0] && wdata_r[STS_TIMEOUT]));
      status_r[STS_RESET] <= fire_reset ||
        (status_r[STS_RESET] && !(wr_status && wstrb_r[0] && wdata_r[STS_RESET]));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= '0;
    end else if (wr_mask && wstrb_r[0]) begin
      mask_r <= wdata_r[STS_W-1:0];
    end
  end

  assign timer_irq = |(status_r & mask_r);

  // read port
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rdata_nxt = '0;
    rd_hit    = 1'b1;
    case (s_axi_araddr)
      ADDR_CONTROL: rdata_nxt[15:0] = control_r;
      ADDR_RELOAD:  rdata_nxt[15:0] = reload_r;
      ADDR_COUNT:   rdata_nxt[15:0] = count_r;
      ADDR_STATUS:  rdata_nxt[STS_W-1:0] = status_r;
      ADDR_MASK:    rdata_nxt[STS_W-1:0] = mask_r;
      default:      rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdata_nxt;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  a_reset_pulse_len: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(system_reset_out) |-> ##127 system_reset_out ##1 !system_reset_out)
    else $error("reset pulse not 128 cycles");

  a_debug_blocks_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    timeout && debug_acknowledge && !system_reset_out |=> !system_reset_out)
    else $error("reset fired during debug");

  a_reset_disabled_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    timeout && !control_r[RST_BIT] && !system_reset_out |=> !system_reset_out)
    else $error("reset fired while disabled");

  // an expiry in the last cycle of a running pulse is swallowed, not re-armed
  a_reset_on_expiry: assert property (@(posedge aclk) disable iff (!aresetn)
    timeout && control_r[RST_BIT] && !debug_acknowledge && !system_reset_out |=> system_reset_out)
    else $error("expiry did not assert reset");

  a_reload_at_timeout: assert property (@(posedge aclk) disable iff (!aresetn)
    timeout && !wr_count |=> count_r == $past(reload_r))
    else $error("counter not reloaded at timeout");

  a_count_decrements: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && !timeout && !wr_count |=> count_r == $past(count_r) - ONE16)
    else $error("counter did not step down");

  a_enable_no_load: assert property (@(posedge aclk) disable iff (!aresetn)
    !enabled ##1 (enabled && !wr_count) |=> $stable(count_r))
    else $error("enable changed the count");

  a_irq_gate_on: assert property (@(posedge aclk) disable iff (!aresetn)
    timeout && control_r[INT_BIT] |=> status_r[STS_TIMEOUT])
    else $error("timeout event not latched");

  a_irq_gate_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !status_r[STS_TIMEOUT] && !(timeout && control_r[INT_BIT]) |=> !status_r[STS_TIMEOUT])
    else $error("timeout event set without cause");

  // helper state for the assertions only; it steers nothing
  logic [15:0] gap_r;
  logic        gap_valid_r;
  logic [7:0]  hi_len_r;

  // cycles since the last tick
  always_ff @(posedge aclk) begin
    if (!aresetn || !enabled) begin
      gap_r <= '0;
    end else if (tick) begin
      gap_r <= ONE16;
    end else begin
      gap_r <= gap_r + ONE16;
    end
  end

  // a control write breaks the period it lands in, so that period is not judged
  always_ff @(posedge aclk) begin
    if (!aresetn || !enabled || wr_ctrl) begin
      gap_valid_r <= 1'b0;
    end else if (tick) begin
      gap_valid_r <= 1'b1;
    end
  end

  // length so far of the running reset pulse
  always_ff @(posedge aclk) begin
    if (!aresetn || !system_reset_out) begin
      hi_len_r <= '0;
    end else begin
      hi_len_r <= hi_len_r + 8'h01;
    end
  end

  a_tick_period: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && gap_valid_r |-> gap_r == period_of(control_r))
    else $error("tick spacing differs from prescaler and divider");

  a_pulse_length: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(system_reset_out) |-> hi_len_r == RST_CYCLES)
    else $error("reset pulse length wrong");

  a_pulse_needs_expiry: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(system_reset_out) |->
      $past(timeout) && $past(control_r[RST_BIT]) && !$past(debug_acknowledge))
    else $error("reset pulse without enabled expiry");

  a_count_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    !tick && !wr_count |=> $stable(count_r))
    else $error("count moved without a tick");

  a_status_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    status_r[STS_TIMEOUT] && !wr_status |=> status_r[STS_TIMEOUT])
    else $error("timeout event lost before software cleared it");

  a_reset_event_latched: assert property (@(posedge aclk) disable iff (!aresetn)
    timeout && control_r[RST_BIT] && !debug_acknowledge && !system_reset_out
    |=> status_r[STS_RESET])
    else $error("reset event not latched");

  a_count_write_lands: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_count && (&wstrb_r[1:0]) |=> count_r == $past(wdata_r[15:0]))
    else $error("count write did not land");

  a_control_write_lands: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ctrl && (&wstrb_r[1:0]) |=> control_r == $past(wdata_r[15:0]))
    else $error("control write did not land");

  a_read_live_count: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && (s_axi_araddr == ADDR_COUNT)
    |=> s_axi_rdata[15:0] == $past(count_r))
    else $error("count read not the live value");

endmodule
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench for the watchdog interval timer, driven over AXI4-Lite
// assumes the register map and status/mask layout of wdt_pkg
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fails++; \
  $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp); end end
module tb_top
  import wdt_pkg::*;
;
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic [31:0] awaddr  = 32'h0;
  logic [31:0] wdata   = 32'h0;
  logic [31:0] araddr  = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        dbg     = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, sys_rst, irq;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] rdata, rd_d;
  int          fails   = 0;
  int          n_tests = 0;
  int          cyc     = 0;
  int          t0, n;

  always #50 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  watchdog_interval_timer DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .debug_acknowledge(dbg),
    .system_reset_out(sys_rst), .timer_irq(irq)
  );

  // handshakes are judged in the low phase, where the combinational readies are settled
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, done;
    done = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      ta   = awvalid & awready;
      tw   = wvalid & wready;
      done = bvalid;
      r    = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, done;
    done = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      ta   = arvalid & arready;
      done = rvalid;
      d    = rdata;
      r    = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  task automatic wait_hi(input bit rs, input int lim);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (!(rs ? sys_rst : irq) && n < lim);
    `CHK(rs ? sys_rst : irq, 1'b1)
  endtask

  task close_out;
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #3000000;
    fails++;
    close_out;
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CONTROL, rd_d, rsp); `CHK(rd_d, {16'h0, CONTROL_RESET})
    rd(ADDR_RELOAD, rd_d, rsp); `CHK(rd_d, 32'h0000_8000)
    rd(ADDR_COUNT, rd_d, rsp); `CHK(rd_d, 32'h0000_8000)
    rd(32'h5300_0014, rd_d, rsp); `CHK({rsp, rd_d}, {RESP_SLVERR, 32'h0})
    wr(32'h5300_0014, 32'h0000_ffff, rsp); `CHK(rsp, RESP_SLVERR)
    // stopped, reserved bits kept at zero, count loaded before enabling
    wr(ADDR_CONTROL, 32'h0000_0004, rsp);
    wr(ADDR_COUNT, 32'h0000_0003, rsp);
    wr(ADDR_RELOAD, 32'h0000_0005, rsp);
    wr(ADDR_MASK, 32'h0000_0001, rsp);
    repeat (40) @(posedge aclk);
    rd(ADDR_COUNT, rd_d, rsp); `CHK(rd_d, 32'h0000_0003)
    wr(ADDR_CONTROL, 32'h0000_0024, rsp);
    rd(ADDR_COUNT, rd_d, rsp); `CHK(rd_d, 32'h0000_0003)
    wait_hi(0, 80);
    rd(ADDR_COUNT, rd_d, rsp); `CHK(rd_d, 32'h0000_0005)
    rd(ADDR_STATUS, rd_d, rsp); `CHK(rd_d, 32'h0000_0001)
    wr(ADDR_STATUS, 32'h0000_0001, rsp);
    @(negedge aclk); `CHK(irq, 1'b0)
    wr(ADDR_MASK, 32'h0000_0000, rsp);
    repeat (100) @(posedge aclk);
    rd(ADDR_STATUS, rd_d, rsp); `CHK(rd_d[0], 1'b1)
    @(negedge aclk); `CHK(irq, 1'b0)
    // period between expiries for every division code, prescaler 1, reload 2
    wr(ADDR_RELOAD, 32'h0000_0002, rsp);
    wr(ADDR_MASK, 32'h0000_0001, rsp);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_CONTROL, 32'h0000_0124 | (s << 3), rsp);
      wr(ADDR_STATUS, 32'h0000_0001, rsp);
      wait_hi(0, 1200);
      t0 = cyc;
      wr(ADDR_STATUS, 32'h0000_0001, rsp);
      wait_hi(0, 1200);
      `CHK(cyc - t0, 2 * 2 * (16 << s))
    end
    wr(ADDR_CONTROL, 32'h0000_0000, rsp);
    wr(ADDR_COUNT, 32'h0000_0002, rsp);
    wr(ADDR_CONTROL, 32'h0000_0021, rsp);
    wait_hi(1, 100);
    // debug raised mid-pulse must not shorten the running pulse;
    // the low phase that wait_hi ended in is the pulse's first cycle
    n = 1;
    @(posedge aclk);
    dbg <= 1'b1;
    @(negedge aclk);
    while (sys_rst) begin
      n++;
      @(negedge aclk);
    end
    `CHK(n, 128)
    n = 0;
    repeat (200) begin
      @(negedge aclk);
      if (sys_rst) n++;
    end
    `CHK(n, 0)
    rd(ADDR_STATUS, rd_d, rsp); `CHK(rd_d[1], 1'b1)
    @(posedge aclk);
    dbg <= 1'b0;
    wait_hi(1, 60);
    wr(ADDR_CONTROL, 32'h0000_0000, rsp);
    close_out;
  end
endmodule
`default_nettype wire
